/* File: scaler_pkg.sv */
// constants, field layout and types of the alarm, peak, zero and output scaler
//
// Contract
// - There are two independent alarm channels, each with its own mode, limits and polarity, each driving one relay.
// - In range mode with high polarity the relay is energized while the value lies between the limits.
// - Low polarity inverts a channel's relay drive, releasing it inside the alarm condition.
// - High mode alarms when the value is greater than the high limit, using only that limit.
// - Low mode alarms when the value is less than the low limit, using only that limit.
// - Voltage output scales the value linearly from the span bottom to 10V at the span top.
// - Current output maps the span bottom to 4mA and the span top to 20mA, linear in between.
// - The span bottom and top are held on their own and are never derived from the sensor full scale.
// - The analog output type is selectable among voltage, current and pulse-width modulation.
// - Peak hold can be started from the touch control and from the remote peak terminal.
// - While peak hold is on, the display shows the greatest value since it began, not the present one.
// - While the remote peak input is held the held peak shows, and on release the actual value returns at once.
// - Zeroing can be started from the touch control or from the remote zero terminal.
// - Each remote zero activation takes the present reading as the new offset, so the display reads zero.
package scaler_pkg;
    localparam int PV_W = 16;
    localparam int NUM_CH = 2;
    localparam int CLK_MHZ = 100;
    localparam int DEBOUNCE_US = 5000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_DISP = 8'h08;
    localparam logic [7:0] OFF_OFFSET = 8'h0c;
    localparam logic [7:0] OFF_ALM_SAVE = 8'h10;
    localparam logic [7:0] OFF_SPAN_BOT = 8'h14;
    localparam logic [7:0] OFF_SPAN_TOP = 8'h18;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h20;
    localparam logic [7:0] OFF_IRQ_EN = 8'h24;
    localparam logic [7:0] OFF_CH_BASE = 8'h40;
    localparam logic [7:0] OFF_CH_STRIDE = 8'h10;
    localparam logic [7:0] OFF_CH_CFG = 8'h00;
    localparam logic [7:0] OFF_CH_LOW = 8'h04;
    localparam logic [7:0] OFF_CH_HIGH = 8'h08;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CTRL_PEAK_BIT = 0;
    localparam int CTRL_ZERO_BIT = 1;
    localparam int CTRL_TYPE_LSB = 2;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_POL_BIT = 2;
    localparam int IRQ_W = 4;
    localparam int IRQ_ZERO_BIT = 2;
    localparam int IRQ_PEAK_BIT = 3;
    // ---------------------------------------------------------------
    // reset values and output codes
    // ---------------------------------------------------------------
    localparam logic [PV_W-1:0] RST_SPAN_BOT = 16'h0000;
    localparam logic [PV_W-1:0] RST_SPAN_TOP = 16'h03e8;
    localparam int VOLT_TOP_MV = 10000;
    localparam int CUR_LO_UA = 4000;
    localparam int CUR_HI_UA = 20000;
    localparam logic [15:0] CODE_FULL = 16'hffff;
    // full code is the top of the span: 10V for voltage, 20mA for current
    localparam logic [15:0] CODE_I4 = 16'((int'(CODE_FULL) * CUR_LO_UA) / CUR_HI_UA);
    localparam logic [15:0] CODE_CUR_SPAN = 16'(CODE_FULL - CODE_I4);

    typedef enum logic [1:0] {ALM_RANGE, ALM_HIGH, ALM_LOW, ALM_OFF} alm_mode_e;
    typedef enum logic [1:0] {OUT_VOLT, OUT_CURR, OUT_PWM, OUT_NONE} out_type_e;
endpackage

/* File: remote_debounce.sv */
// synchroniser and debouncer for one active-low remote contact input
`timescale 1ns/1ps
`default_nettype none
module remote_debounce #(
    parameter int CNT_MAX = scaler_pkg::DEBOUNCE_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic contact_n,
    output logic      active
);
    localparam int CW = $clog2(CNT_MAX + 1);

    typedef struct packed {
        logic          s1;
        logic          s2;
        logic          level;
        logic [CW-1:0] cnt;
    } deb_s;

    deb_s st_r;
    deb_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = ~contact_n;
        st_nxt.s2 = st_r.s1;
        // level only moves after the input has held the new value for the whole window
        if (st_r.s2 == st_r.level) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt == CW'(CNT_MAX - 1)) begin
            st_nxt.cnt = '0;
            st_nxt.level = st_r.s2;
        end else begin
            st_nxt.cnt = st_r.cnt + CW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign active = st_r.level;
endmodule
`default_nettype wire

/* File: alarm_scaler.sv */
// alarm relays, peak hold, zero offset and analog output scaling behind an apb slave
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module alarm_scaler #(
    parameter int DEBOUNCE_CNT = scaler_pkg::DEBOUNCE_CYCLES
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic [7:0]                    paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   pwdata,
    output logic [31:0]                        prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic signed [scaler_pkg::PV_W-1:0] pv,
    input  wire logic                          peak_remote_n,
    input  wire logic                          zero_remote_n,
    output logic                               relay_one_contact,
    output logic                               relay_two_contact,
    output logic [15:0]                        aout_code,
    output logic                               aout_current,
    output logic                               pwm_out,
    output logic                               irq
);
    import scaler_pkg::*;

    typedef logic signed [PV_W-1:0] val_t;

    typedef struct packed {
        logic [31:0]             prdata;
        logic                    peak_touch;
        logic [1:0]              out_type;
        logic [NUM_CH-1:0][1:0]  stg_mode;
        logic [NUM_CH-1:0]       stg_pol;
        logic [NUM_CH-1:0][PV_W-1:0] stg_lo;
        logic [NUM_CH-1:0][PV_W-1:0] stg_hi;
        logic [NUM_CH-1:0][1:0]  act_mode;
        logic [NUM_CH-1:0]       act_pol;
        logic [NUM_CH-1:0][PV_W-1:0] act_lo;
        logic [NUM_CH-1:0][PV_W-1:0] act_hi;
        logic [NUM_CH-1:0]       relay;
        logic [PV_W-1:0]         span_bot;
        logic [PV_W-1:0]         span_top;
        logic [PV_W-1:0]         offset;
        logic [PV_W-1:0]         peak;
        logic                    peak_on;
        logic                    zero_q;
        logic [IRQ_W-1:0]        irq_stat;
        logic [IRQ_W-1:0]        irq_en;
        logic [15:0]             aout;
        logic [7:0]              pwm_cnt;
        logic                    pwm;
    } st_s;

    st_s st_r;
    st_s st_nxt;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic alarm_cond(input logic [1:0] mode, input val_t lo, input val_t hi, input val_t v);
        logic c;
        c = 1'b0;
        case (alm_mode_e'(mode))
            ALM_RANGE: c = (v >= lo) && (v <= hi);
            ALM_HIGH:  c = v > hi;
            ALM_LOW:   c = v < lo;
            default:   c = 1'b0;
        endcase
        return c;
    endfunction

    function automatic logic [7:0] ch_addr(input int ch, input logic [7:0] reg_off);
        return 8'(OFF_CH_BASE + 8'(ch) * OFF_CH_STRIDE + reg_off);
    endfunction

    logic peak_lvl;
    logic zero_lvl;

    remote_debounce #(.CNT_MAX(DEBOUNCE_CNT)) u_peak_deb (
        .pclk      (pclk),
        .presetn   (presetn),
        .contact_n (peak_remote_n),
        .active    (peak_lvl)
    );

    remote_debounce #(.CNT_MAX(DEBOUNCE_CNT)) u_zero_deb (
        .pclk      (pclk),
        .presetn   (presetn),
        .contact_n (zero_remote_n),
        .active    (zero_lvl)
    );

    val_t rel;
    val_t disp;
    logic setup;
    logic wr;
    logic known;
    logic zero_ev;
    logic peak_req;
    logic signed [PV_W:0] diff;
    logic signed [PV_W:0] span;
    logic [47:0] num;
    logic [15:0] frac;
    logic [31:0] rd;
    logic [IRQ_W-1:0] ev;

    assign rel = val_t'(pv - val_t'(st_r.offset));
    assign disp = st_r.peak_on ? val_t'(st_r.peak) : rel;
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;

    always_comb begin
        st_nxt = st_r;
        rd = 32'h0;
        known = 1'b1;
        num = 48'h0;
        frac = 16'h0;
        ev = '0;
        // -----------------------------------------------------------
        // apb read mux, captured in setup so data stands in access
        // -----------------------------------------------------------
        if (paddr == OFF_CTRL) begin
            rd[CTRL_PEAK_BIT] = st_r.peak_touch;
            rd[CTRL_TYPE_LSB +: 2] = st_r.out_type;
        end else if (paddr == OFF_STATUS) begin
            rd[NUM_CH+2:0] = {zero_lvl, peak_lvl, st_r.peak_on, st_r.relay};
        end else if (paddr == OFF_DISP) begin
            rd[PV_W-1:0] = disp;
        end else if (paddr == OFF_OFFSET) begin
            rd[PV_W-1:0] = st_r.offset;
        end else if (paddr == OFF_ALM_SAVE || paddr == OFF_IRQ_CLR) begin
            rd = 32'h0;
        end else if (paddr == OFF_SPAN_BOT) begin
            rd[PV_W-1:0] = st_r.span_bot;
        end else if (paddr == OFF_SPAN_TOP) begin
            rd[PV_W-1:0] = st_r.span_top;
        end else if (paddr == OFF_IRQ_STAT) begin
            rd[IRQ_W-1:0] = st_r.irq_stat;
        end else if (paddr == OFF_IRQ_EN) begin
            rd[IRQ_W-1:0] = st_r.irq_en;
        end else begin
            known = 1'b0;
            for (int c = 0; c < NUM_CH; c++) begin
                if (paddr == ch_addr(c, OFF_CH_CFG)) begin
                    known = 1'b1;
                    rd[CFG_POL_BIT:0] = {st_r.stg_pol[c], st_r.stg_mode[c]};
                end else if (paddr == ch_addr(c, OFF_CH_LOW)) begin
                    known = 1'b1;
                    rd[PV_W-1:0] = st_r.stg_lo[c];
                end else if (paddr == ch_addr(c, OFF_CH_HIGH)) begin
                    known = 1'b1;
                    rd[PV_W-1:0] = st_r.stg_hi[c];
                end
            end
        end
        if (setup) begin
            st_nxt.prdata = rd;
        end
        // -----------------------------------------------------------
        // apb writes; channel settings land in staging only
        // -----------------------------------------------------------
        zero_ev = zero_lvl && !st_r.zero_q;
        if (wr) begin
            if (paddr == OFF_CTRL) begin
                st_nxt.peak_touch = pwdata[CTRL_PEAK_BIT];
                st_nxt.out_type = pwdata[CTRL_TYPE_LSB +: 2];
                zero_ev = zero_ev || pwdata[CTRL_ZERO_BIT];
            end else if (paddr == OFF_ALM_SAVE) begin
                for (int c = 0; c < NUM_CH; c++) begin
                    if (pwdata[c]) begin
                        // all four fields move in one edge, never piecemeal
                        st_nxt.act_mode[c] = st_r.stg_mode[c];
                        st_nxt.act_pol[c] = st_r.stg_pol[c];
                        st_nxt.act_lo[c] = st_r.stg_lo[c];
                        st_nxt.act_hi[c] = st_r.stg_hi[c];
                    end
                end
            end else if (paddr == OFF_SPAN_BOT) begin
                st_nxt.span_bot = pwdata[PV_W-1:0];
            end else if (paddr == OFF_SPAN_TOP) begin
                st_nxt.span_top = pwdata[PV_W-1:0];
            end else if (paddr == OFF_IRQ_CLR) begin
                st_nxt.irq_stat = st_r.irq_stat & ~pwdata[IRQ_W-1:0];
            end else if (paddr == OFF_IRQ_EN) begin
                st_nxt.irq_en = pwdata[IRQ_W-1:0];
            end else begin
                for (int c = 0; c < NUM_CH; c++) begin
                    if (paddr == ch_addr(c, OFF_CH_CFG)) begin
                        st_nxt.stg_mode[c] = pwdata[CFG_MODE_LSB +: 2];
                        st_nxt.stg_pol[c] = pwdata[CFG_POL_BIT];
                    end else if (paddr == ch_addr(c, OFF_CH_LOW)) begin
                        st_nxt.stg_lo[c] = pwdata[PV_W-1:0];
                    end else if (paddr == ch_addr(c, OFF_CH_HIGH)) begin
                        st_nxt.stg_hi[c] = pwdata[PV_W-1:0];
                    end
                end
            end
        end
        // -----------------------------------------------------------
        // zero and peak hold
        // -----------------------------------------------------------
        st_nxt.zero_q = zero_lvl;
        if (zero_ev) begin
            st_nxt.offset = pv;
        end
        peak_req = st_r.peak_touch || peak_lvl;
        st_nxt.peak_on = peak_req;
        if (peak_req && !st_r.peak_on) begin
            st_nxt.peak = rel;
        end else if (peak_req && rel > val_t'(st_r.peak)) begin
            st_nxt.peak = rel;
        end
        // -----------------------------------------------------------
        // alarm channels
        // -----------------------------------------------------------
        for (int c = 0; c < NUM_CH; c++) begin
            // low polarity flips the drive, not the condition
            st_nxt.relay[c] = alarm_cond(st_r.act_mode[c], val_t'(st_r.act_lo[c]), val_t'(st_r.act_hi[c]), disp)
                              ^ st_r.act_pol[c];
            ev[c] = st_nxt.relay[c] != st_r.relay[c];
        end
        // -----------------------------------------------------------
        // linear scaling of the displayed value onto the span
        // -----------------------------------------------------------
        diff = {disp[PV_W-1], disp} - {st_r.span_bot[PV_W-1], st_r.span_bot};
        span = {st_r.span_top[PV_W-1], st_r.span_top} - {st_r.span_bot[PV_W-1], st_r.span_bot};
        if (span <= 0 || diff <= 0) begin
            frac = 16'h0;
        end else if (diff >= span) begin
            frac = CODE_FULL;
        end else begin
            num = 48'(diff[PV_W-1:0]) * 48'(CODE_FULL);
            frac = 16'(num / 48'(span[PV_W-1:0]));
        end
        if (out_type_e'(st_r.out_type) == OUT_CURR) begin
            // divide by full code, not shift, so the span top lands exactly on full scale
            st_nxt.aout = 16'(CODE_I4 + 16'((32'(frac) * 32'(CODE_CUR_SPAN)) / 32'(CODE_FULL)));
        end else begin
            st_nxt.aout = frac;
        end
        st_nxt.pwm_cnt = st_r.pwm_cnt + 8'h01;
        // top of span gives 255 of 256 slots high
        st_nxt.pwm = (out_type_e'(st_r.out_type) == OUT_PWM) && (st_r.pwm_cnt < frac[15:8]);
        // -----------------------------------------------------------
        // interrupt sources: relay changes, zero taken, peak start
        // -----------------------------------------------------------
        ev[IRQ_ZERO_BIT] = zero_ev;
        ev[IRQ_PEAK_BIT] = peak_req && !st_r.peak_on;
        st_nxt.irq_stat = st_nxt.irq_stat | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.stg_mode <= {NUM_CH{ALM_OFF}};
            st_r.act_mode <= {NUM_CH{ALM_OFF}};
            st_r.span_bot <= RST_SPAN_BOT;
            st_r.span_top <= RST_SPAN_TOP;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !known;
    assign relay_one_contact = st_r.relay[0];
    assign relay_two_contact = st_r.relay[1];
    assign aout_code = st_r.aout;
    assign aout_current = out_type_e'(st_r.out_type) == OUT_CURR;
    assign pwm_out = st_r.pwm;
    assign irq = |(st_r.irq_stat & st_r.irq_en);

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_peak_release;
        st_r.peak_on && !peak_req;
    endsequence

    sequence s_cfg_write_only;
        wr && paddr == ch_addr(0, OFF_CH_CFG);
    endsequence

    a_high_mode_relay: assert property (
        alm_mode_e'(st_r.act_mode[0]) == ALM_HIGH && !st_r.act_pol[0] && disp > val_t'(st_r.act_hi[0])
        |=> relay_one_contact) else $error("high mode did not energize relay one");
    a_low_mode_relay: assert property (
        alm_mode_e'(st_r.act_mode[0]) == ALM_LOW && !st_r.act_pol[0] && disp >= val_t'(st_r.act_lo[0])
        |=> !relay_one_contact) else $error("low mode energized relay one at or above limit");
    a_range_inclusive: assert property (
        alm_mode_e'(st_r.act_mode[0]) == ALM_RANGE && !st_r.act_pol[0] && disp == val_t'(st_r.act_lo[0])
        |=> relay_one_contact) else $error("range low limit not inclusive");
    a_polarity_invert: assert property (
        alm_mode_e'(st_r.act_mode[1]) == ALM_RANGE && st_r.act_pol[1] && disp > val_t'(st_r.act_hi[1])
        |=> relay_two_contact) else $error("low polarity did not energize outside range");
    a_save_only_commit: assert property (
        s_cfg_write_only |=> $stable(st_r.act_mode) && $stable(st_r.act_pol)) else $error("config applied without save");
    a_peak_nondecrease: assert property (
        st_r.peak_on && $past(st_r.peak_on) |-> disp >= $past(disp)) else $error("held peak fell");
    a_peak_release_now: assert property (
        s_peak_release |=> !st_r.peak_on && disp == rel) else $error("display not actual after peak release");
    a_zero_offset: assert property (
        zero_lvl && !st_r.zero_q |=> st_r.offset == $past(pv)) else $error("zero did not take reading");
    a_volt_top: assert property (
        out_type_e'(st_r.out_type) == OUT_VOLT && span > 0 && diff >= span ##1 1'b1
        |-> aout_code == CODE_FULL) else $error("voltage top not full scale");
    a_cur_bottom: assert property (
        out_type_e'(st_r.out_type) == OUT_CURR && diff <= 0 |=> aout_code == CODE_I4) else $error("current bottom not 4mA");
endmodule
`default_nettype wire

/* File: remote_buttons.sv */
// momentary pushbuttons wired from the remote inputs to ground
`timescale 1ns/1ps
`default_nettype none
module remote_buttons (
    input  wire logic peak_press,
    input  wire logic zero_press,
    output logic      peak_remote_n,
    output logic      zero_remote_n
);
    // open contact floats up through the pull-up, closed pulls to ground
    assign peak_remote_n = peak_press ? 1'b0 : 1'b1;
    assign zero_remote_n = zero_press ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: test_alarm_peak_zero_output_scaler.sv */
// self-checking testbench of the alarm, peak, zero and output scaler
`timescale 1ns/1ps
`default_nettype none
module test_alarm_peak_zero_output_scaler;
    import scaler_pkg::*;
    logic                   pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic [7:0]             paddr = 8'h00;
    logic [31:0]            pwdata = 32'h0, prdata, q;
    logic signed [PV_W-1:0] pv = '0;
    logic                   pready, pslverr, rly1, rly2, cur, pwm_out, irq, peak_n, zero_n;
    logic                   peak_press = 0, zero_press = 0;
    logic [15:0]            aout;
    int                     err_count = 0, n_checks = 0;
    localparam logic [7:0]  CH1 = OFF_CH_BASE + OFF_CH_STRIDE;

    always #5 pclk = ~pclk;

    alarm_scaler #(.DEBOUNCE_CNT(4)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pv(pv), .peak_remote_n(peak_n), .zero_remote_n(zero_n),
        .relay_one_contact(rly1), .relay_two_contact(rly2), .aout_code(aout), .aout_current(cur),
        .pwm_out(pwm_out), .irq(irq));
    remote_buttons buttons (.peak_press(peak_press), .zero_press(zero_press),
        .peak_remote_n(peak_n), .zero_remote_n(zero_n));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // master waits on pready, never assuming a latency; only the watchdog ends a hang
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; paddr <= a; pwrite <= wr; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task wait_cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task step(input logic signed [PV_W-1:0] v);
        @(posedge pclk);
        pv <= v;
        wait_cyc(5);
    endtask
    task relays(input logic signed [PV_W-1:0] v, input logic r1, input logic r2);
        step(v);
        chk("relays", {30'h0, r2, r1}, {30'h0, rly2, rly1});
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task test_regs;
        rd(OFF_SPAN_BOT); chk("span bottom", 32'h0, q);
        rd(OFF_SPAN_TOP); chk("span top", 32'h3e8, q);
        rd(8'hfc); chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        $display("test regs done");
    endtask
    task test_alarm;
        wr(OFF_CH_BASE + OFF_CH_CFG, 32'h0); wr(OFF_CH_BASE + OFF_CH_LOW, 100); wr(OFF_CH_BASE + OFF_CH_HIGH, 200);
        wr(CH1 + OFF_CH_CFG, 32'h4); wr(CH1 + OFF_CH_LOW, 100); wr(CH1 + OFF_CH_HIGH, 200);
        relays(150, 0, 0);
        wr(OFF_ALM_SAVE, 32'h3);
        relays(150, 1, 0);
        relays(100, 1, 0);
        relays(99, 0, 1);
        relays(200, 1, 0);
        relays(201, 0, 1);
        wr(OFF_CH_BASE + OFF_CH_CFG, 32'h1);
        relays(201, 0, 1);
        wr(OFF_ALM_SAVE, 32'h1);
        relays(200, 0, 0);
        relays(201, 1, 1);
        wr(OFF_CH_BASE + OFF_CH_CFG, 32'h2); wr(OFF_ALM_SAVE, 32'h1);
        relays(100, 0, 0);
        relays(99, 1, 1);
        $display("test alarm done");
    endtask
    task test_scale;
        int hi;
        wr(OFF_CTRL, 32'h0);
        step(0); chk("volt bottom", 32'h0, {16'h0, aout});
        step(1000); chk("volt top", 32'hffff, {16'h0, aout});
        chk("current flag", 32'h0, {31'h0, cur});
        chk("pwm idle", 32'h0, {31'h0, pwm_out});
        wr(OFF_CTRL, 32'h4);
        step(0); chk("cur bottom", {16'h0, CODE_I4}, {16'h0, aout});
        chk("current flag", 32'h1, {31'h0, cur});
        step(1000); chk("cur top", 32'hffff, {16'h0, aout});
        wr(OFF_CTRL, 32'h8); rd(OFF_CTRL); chk("pwm type", 32'h8, q & 32'hc);
        // value sits at span top: one full period of 256 slots has all but one high
        hi = 0;
        repeat (256) begin
            @(posedge pclk);
            hi += pwm_out;
        end
        chk("pwm duty", 32'd255, 32'(hi));
        wr(OFF_CTRL, 32'h0); wr(OFF_SPAN_BOT, 10); wr(OFF_SPAN_TOP, 60);
        step(10); chk("span 10", 32'h0, {16'h0, aout});
        step(60); chk("span 60", 32'hffff, {16'h0, aout});
        $display("test scale done");
    endtask
    task test_zero;
        wr(OFF_IRQ_EN, 32'h4); wr(OFF_IRQ_CLR, 32'hf); wait_cyc(1);
        chk("irq idle", 32'h0, {31'h0, irq});
        step(300);
        zero_press <= 1; wait_cyc(20); zero_press <= 0; wait_cyc(20);
        rd(OFF_DISP); chk("disp zeroed", 32'h0, q);
        rd(OFF_OFFSET); chk("offset", 32'd300, q);
        chk("irq zero", 32'h1, {31'h0, irq});
        step(350); rd(OFF_DISP); chk("disp rel", 32'd50, q);
        wr(OFF_IRQ_EN, 32'h0); wait_cyc(1); chk("irq masked", 32'h0, {31'h0, irq});
        wr(OFF_IRQ_EN, 32'h4); wait_cyc(1); chk("irq unmask", 32'h1, {31'h0, irq});
        wr(OFF_IRQ_CLR, 32'h4); wait_cyc(1); chk("irq clear", 32'h0, {31'h0, irq});
        step(120); wr(OFF_CTRL, 32'h2);
        rd(OFF_OFFSET); chk("touch offset", 32'd120, q);
        $display("test zero done");
    endtask
    task test_peak;
        step(0); wr(OFF_CTRL, 32'h2); step(100);
        peak_press <= 1; wait_cyc(20);
        step(500); step(200);
        rd(OFF_DISP); chk("remote peak", 32'd500, q);
        peak_press <= 0; wait_cyc(20);
        rd(OFF_DISP); chk("peak release", 32'd200, q);
        wr(OFF_CTRL, 32'h1); step(400); step(50);
        rd(OFF_DISP); chk("touch peak", 32'd400, q);
        wr(OFF_CTRL, 32'h0); wait_cyc(3);
        rd(OFF_DISP); chk("touch off", 32'd50, q);
        $display("test peak done");
    endtask

    // ---------------------------------------------------------------
    // run control
    // ---------------------------------------------------------------
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        test_regs;
        test_alarm;
        test_scale;
        test_zero;
        test_peak;
        print_verdict;
    end
    // whole sequence needs well under a thousand cycles
    initial begin
        #200000;
        err_count++;
        print_verdict;
    end
endmodule
`default_nettype wire
